// File: hw/pnccg_pkg.sv
// =============================================================================
// Shared constants and step functions of the pseudo-noise code clock generator
// =============================================================================
// Holds the stage counts, seeds, detector patterns and rates used by all files.
// Assumes one system clock and an asynchronous active-high reset everywhere.
//
// Functional notes
// - Fast and slow recurrences with given seeds
// - Newer bits sit in lower-numbered stages
// - State signal high only for that bit
// - Nine-stage generator with 255, 510, zero decoders
// - Zero detector forces generator out of lockup
// - Phase slip loads zero into stage two
// - Slip after 510 delays sequence two bits
// - Detectors 510 and 255 retimed once
// - Frame falls after 511, rises after 256
// - Half-frame toggles at 511; xor at 256
// - All frame signals registered on fast clock
// - Slow tick coincides with half-frame falling
// - Slow tick once per two fast sequence periods
// - Fast gate is reference divided by two
// - Fast clock is reference gated by gate
// - Slow clock is reference gated by slow gate
// - Fast square wave re-registered on reference
// - Everything derives from the one reference
// - Half-frame period is 2044 reference cycles
package pnccg_pkg;

    // Generator sizes and periods
    localparam int unsigned H_STAGES     = 9;
    localparam int unsigned L_STAGES     = 7;
    localparam int unsigned H_PERIOD     = 511;
    localparam int unsigned L_PERIOD     = 127;
    localparam int unsigned SLOW_DIVIDE  = 1022;
    localparam int unsigned FRAME_DIVIDE = 2044;
    localparam int unsigned H_SLIP_BITS  = 2;

    // Rates in kHz
    localparam int unsigned REF_KHZ = 12800;
    localparam int unsigned SYS_KHZ = 100000;

    // Seeds: first bit in the last stage, newer bits toward stage one
    localparam logic [H_STAGES-1:0] H_SEED       = 9'h0_002;
    localparam logic [L_STAGES-1:0] L_SEED       = 7'h02;
    localparam logic [H_STAGES-1:0] H_SLIP_STATE = 9'h0_001;
    localparam logic [H_STAGES-1:0] H_ZERO_STATE = 9'h0_000;

    // One fast step; stage i is bit i-1 of the vector
    function automatic logic [H_STAGES-1:0] pnccg_h_step(input logic [H_STAGES-1:0] st, input logic slip);
        logic [H_STAGES-1:0] nxt;
        nxt         = {st[H_STAGES-2:0], 1'b0};
        nxt[0]      = (st[8] ^ st[3]) | (st[7:0] == 8'h00);
        nxt[1]      = slip ? 1'b0 : st[0];
        return nxt;
    endfunction

    // One slow step with the same lockup guard over six stages
    function automatic logic [L_STAGES-1:0] pnccg_l_step(input logic [L_STAGES-1:0] st);
        logic [L_STAGES-1:0] nxt;
        nxt    = {st[L_STAGES-2:0], 1'b0};
        nxt[0] = (st[6] ^ st[5]) | (st[5:0] == 6'h00);
        return nxt;
    endfunction

    // State reached after n unslipped steps from the seed
    function automatic logic [H_STAGES-1:0] pnccg_h_walk(input int unsigned n);
        logic [H_STAGES-1:0] st;
        st = H_SEED;
        for (int unsigned i = 0; i < n; i++)
        begin
            st = pnccg_h_step(st, 1'b0);
        end
        return st;
    endfunction

    // Decoder patterns: bit 255 and bit 510 in the last stage
    localparam logic [H_STAGES-1:0] H_DET_255 = pnccg_h_walk(254);
    localparam logic [H_STAGES-1:0] H_DET_510 = pnccg_h_walk(509);

endpackage

// File: hw/pnccg_seq_if.sv
// =============================================================================
// Link between the timing core and its two sequence generators
// =============================================================================
// Carries the clock enables, the slip request and the generator states.
// Assumes all signals live in the single system clock domain.
interface pnccg_seq_if import pnccg_pkg::*; ();
    logic                fast_tick;
    logic                slow_tick;
    logic                slip;
    logic [H_STAGES-1:0] h_state;
    logic                h_det_255;
    logic                h_det_510;
    logic                h_zero8;
    logic [L_STAGES-1:0] l_state;

    modport hgen (input fast_tick, slip, output h_state, h_det_255, h_det_510, h_zero8);
    modport lgen (input slow_tick, output l_state);
    modport ctrl (output fast_tick, slow_tick, slip, input h_state, h_det_255, h_det_510, h_zero8, l_state);
endinterface

// File: hw/pnccg_hgen.sv
// =============================================================================
// Nine-stage fast sequence generator with word detectors and phase slip
// =============================================================================
// Steps once per fast clock enable. Assumes slip is only meaningful on a tick.
module pnccg_hgen import pnccg_pkg::*;
(
    // Clock and reset
    input  wire logic   sys_clk_i,
    input  wire logic   sys_rst_i,
    // Sequence link
    pnccg_seq_if.hgen   seq
);

    logic [H_STAGES-1:0] state_ff;
    logic [H_STAGES-1:0] nxt_state;

    // Feedback, lockup guard and slip into stage two
    assign nxt_state = pnccg_h_step(state_ff, seq.slip);

    // Shift register, seeded on reset
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            state_ff <= H_SEED;
        else if (seq.fast_tick)
            state_ff <= nxt_state;
    end

    // Word detectors
    assign seq.h_state   = state_ff;
    assign seq.h_det_255 = (state_ff == H_DET_255);
    assign seq.h_det_510 = (state_ff == H_DET_510);
    assign seq.h_zero8   = (state_ff[7:0] == 8'h00);

    // =========================================================================
    // Assertions
    // =========================================================================
    property p_zero_escape;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (seq.fast_tick && state_ff == H_ZERO_STATE) |=> state_ff == H_SLIP_STATE;
    endproperty
    a_zero_escape: assert property (p_zero_escape) else $error("Zero state not left");

    property p_slip_zero;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (seq.fast_tick && seq.slip && state_ff == H_SLIP_STATE) |=> state_ff == H_ZERO_STATE;
    endproperty
    a_slip_zero: assert property (p_slip_zero) else $error("Slip did not insert zero");

    property p_slip_stage2;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (seq.fast_tick && seq.slip) |=> !state_ff[1];
    endproperty
    a_slip_stage2: assert property (p_slip_stage2) else $error("Stage two not zero after slip");

endmodule

// File: hw/pnccg_lgen.sv
// =============================================================================
// Seven-stage slow sequence generator
// =============================================================================
// Steps once per slow clock enable. Assumes the enable is a one-cycle pulse.
module pnccg_lgen import pnccg_pkg::*;
(
    // Clock and reset
    input  wire logic   sys_clk_i,
    input  wire logic   sys_rst_i,
    // Sequence link
    pnccg_seq_if.lgen   seq
);

    logic [L_STAGES-1:0] state_ff;

    // Shift register with recurrence feedback
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            state_ff <= L_SEED;
        else if (seq.slow_tick)
            state_ff <= pnccg_l_step(state_ff);
    end

    assign seq.l_state = state_ff;

    property p_l_recur;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (seq.slow_tick && state_ff[5:0] != 6'h00) |=> state_ff[0] == ($past(state_ff[6]) ^ $past(state_ff[5]));
    endproperty
    a_l_recur: assert property (p_l_recur) else $error("Slow recurrence broken");

endmodule

// File: hw/pnccg_top.sv
// =============================================================================
// Pseudo-noise code clock generator, timing core
// =============================================================================
// Shapes the double-rate reference into fast and slow code clock enables,
// runs both sequence generators and builds the frame-rate waveforms.
// Assumes the reference input is already synchronous to sys_clk_i and that
// the system clock is at least four times the reference rate.
module pnccg_top import pnccg_pkg::*;
#(
    parameter int unsigned SYS_CLK_KHZ = SYS_KHZ,
    parameter int unsigned REF_CLK_KHZ = REF_KHZ
)
(
    // Clock and reset
    input  wire logic                sys_clk_i,
    input  wire logic                sys_rst_i,
    // Reference and phase control
    input  wire logic                double_rate_reference_i,
    input  wire logic                phase_slip_i,
    // Clock enables and gates
    output logic                     fast_code_clock_o,
    output logic                     slow_code_clock_o,
    output logic                     fast_clock_gate_o,
    output logic                     slow_clock_gate_o,
    output logic                     fast_square_o,
    // Sequences
    output logic [H_STAGES-1:0]      fast_stages_o,
    output logic [L_STAGES-1:0]      slow_stages_o,
    output logic                     fast_seq_o,
    output logic                     slow_seq_o,
    // Frame timing
    output logic                     state_256_o,
    output logic                     state_511_o,
    output logic                     frame_o,
    output logic                     half_frame_o,
    output logic                     frame_xor_o
);

    // =========================================================================
    // Elaboration checks
    // =========================================================================
    // The reference must be sampled with at least two clocks per half period
    if (SYS_CLK_KHZ < 4 * REF_CLK_KHZ)
    begin : g_rate_check
        $error("System clock too slow for the reference");
    end

    // =========================================================================
    // Declarations
    // =========================================================================
    pnccg_seq_if seq ();

    logic ref_d_ff;
    logic fast_gate_ff;
    logic fast_square_ff;
    logic h511_ff;
    logic h256_ff;
    logic frame_ff;
    logic half_ff;
    logic xor_ff;

    logic ref_tick;
    logic fast_tick;
    logic slow_gate;
    logic slow_tick;
    logic fall_511;
    logic fall_256;
    logic nxt_frame;
    logic nxt_half;

    // =========================================================================
    // Reference shaping
    // =========================================================================
    // Rising edge of the reference marks one double-rate period
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            ref_d_ff <= 1'b0;
        else
            ref_d_ff <= double_rate_reference_i;
    end

    // One-cycle tick per reference period
    assign ref_tick = double_rate_reference_i & ~ref_d_ff;

    // Divide by two to form the fast gate
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            fast_gate_ff <= 1'b0;
        else if (ref_tick)
            fast_gate_ff <= ~fast_gate_ff;
    end

    // Square wave re-registered on the reference
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            fast_square_ff <= 1'b0;
        else if (ref_tick)
            fast_square_ff <= fast_gate_ff;
    end

    // =========================================================================
    // Clock enables
    // =========================================================================
    // Fast enable: reference gated by the fast gate; slow enable reuses the
    // same reference tick so both stay aligned to one edge
    assign fast_tick = ref_tick & fast_gate_ff;
    assign slow_gate = h511_ff & half_ff & fast_gate_ff;
    assign slow_tick = ref_tick & slow_gate;

    assign seq.fast_tick = fast_tick;
    assign seq.slow_tick = slow_tick;
    assign seq.slip      = phase_slip_i;

    // =========================================================================
    // Sequence generators
    // =========================================================================
    pnccg_hgen u_hgen
    (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .seq       (seq.hgen)
    );

    pnccg_lgen u_lgen
    (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .seq       (seq.lgen)
    );

    // =========================================================================
    // Retimed state pulses
    // =========================================================================
    // Detectors for 510 and 255 delayed by one fast clock
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            h511_ff <= 1'b0;
            h256_ff <= 1'b0;
        end
        else if (fast_tick)
        begin
            h511_ff <= seq.h_det_510;
            h256_ff <= seq.h_det_255;
        end
    end

    // Falling edges of the retimed pulses, seen at the fast tick
    assign fall_511 = fast_tick & h511_ff & ~seq.h_det_510;
    assign fall_256 = fast_tick & h256_ff & ~seq.h_det_255;

    // =========================================================================
    // Frame waveforms
    // =========================================================================
    // Frame low after 511, high after 256; half-frame toggles after 511
    assign nxt_frame = fall_511 ? 1'b0 : (fall_256 ? 1'b1 : frame_ff);
    assign nxt_half  = fall_511 ? ~half_ff : half_ff;

    // All frame outputs share the fast enable
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            frame_ff <= 1'b0;
            half_ff  <= 1'b0;
            xor_ff   <= 1'b0;
        end
        else if (fast_tick)
        begin
            frame_ff <= nxt_frame;
            half_ff  <= nxt_half;
            xor_ff   <= nxt_frame ^ nxt_half;
        end
    end

    // =========================================================================
    // Outputs
    // =========================================================================
    // Enables are combinational pulses and the slow gate is combinational; the rest come from flip-flops
    assign fast_code_clock_o = fast_tick;
    assign slow_code_clock_o = slow_tick;
    assign fast_clock_gate_o = fast_gate_ff;
    assign slow_clock_gate_o = slow_gate;
    assign fast_square_o     = fast_square_ff;
    assign fast_stages_o     = seq.h_state;
    assign slow_stages_o     = seq.l_state;
    assign fast_seq_o        = seq.h_state[H_STAGES-1];
    assign slow_seq_o        = seq.l_state[L_STAGES-1];
    assign state_256_o       = h256_ff;
    assign state_511_o       = h511_ff;
    assign frame_o           = frame_ff;
    assign half_frame_o      = half_ff;
    assign frame_xor_o       = xor_ff;

    // =========================================================================
    // Assertion helpers
    // =========================================================================
    // Fast ticks since the last slow tick, and whether one has been seen
    logic [10:0] chk_fast_cnt_ff;
    logic        chk_slow_seen_ff;
    logic [9:0]  chk_frame_cnt_ff;
    logic        chk_frame_seen_ff;
    logic [10:0] chk_slow_extra_ff;
    logic        chk_frame_slip_ff;

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            chk_fast_cnt_ff   <= 11'h000;
            chk_slow_seen_ff  <= 1'b0;
            chk_slow_extra_ff <= 11'h000;
        end
        else if (slow_tick)
        begin
            chk_fast_cnt_ff   <= 11'h001;
            chk_slow_seen_ff  <= 1'b1;
            chk_slow_extra_ff <= phase_slip_i ? 11'(H_SLIP_BITS) : 11'h000;
        end
        else if (fast_tick)
        begin
            // A slip at the end of 511 adds two ticks; any other slip voids the count
            chk_fast_cnt_ff <= chk_fast_cnt_ff + 11'h001;
            if (phase_slip_i && fall_511)
                chk_slow_extra_ff <= chk_slow_extra_ff + 11'(H_SLIP_BITS);
            else if (phase_slip_i)
                chk_slow_seen_ff  <= 1'b0;
        end
    end

    // Fast ticks between frame falls
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            chk_frame_cnt_ff  <= 10'h000;
            chk_frame_seen_ff <= 1'b0;
            chk_frame_slip_ff <= 1'b0;
        end
        else if (fall_511)
        begin
            chk_frame_cnt_ff  <= 10'h001;
            chk_frame_seen_ff <= 1'b1;
            chk_frame_slip_ff <= phase_slip_i;
        end
        else if (fast_tick)
        begin
            // A slip away from the end of 511 leaves the period unknown
            chk_frame_cnt_ff  <= chk_frame_cnt_ff + 10'h001;
            if (phase_slip_i)
                chk_frame_seen_ff <= 1'b0;
        end
    end

    // =========================================================================
    // Assertions
    // =========================================================================
    property p_fast_gate_div;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        ref_tick |=> fast_gate_ff != $past(fast_gate_ff);
    endproperty
    a_fast_gate_div: assert property (p_fast_gate_div) else $error("Fast gate did not divide");

    property p_fast_tick_gated;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        fast_tick |-> ref_tick && fast_gate_ff ##1 !fast_gate_ff;
    endproperty
    a_fast_tick_gated: assert property (p_fast_tick_gated) else $error("Fast tick not gated");

    property p_square_follow;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        ref_tick |=> fast_square_ff == $past(fast_gate_ff);
    endproperty
    a_square_follow: assert property (p_square_follow) else $error("Square wave not re-registered");

    property p_h511_retime;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (fast_tick && seq.h_det_510) |=> h511_ff ##1 (h511_ff throughout !fast_tick [*1]);
    endproperty
    a_h511_retime: assert property (p_h511_retime) else $error("Retimed 511 missing");

    property p_h256_retime;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(h256_ff) |-> $past(seq.h_det_255) && $past(fast_tick);
    endproperty
    a_h256_retime: assert property (p_h256_retime) else $error("Retimed 256 without detector");

    property p_h511_state;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(h511_ff) |-> $past(seq.h_state) == H_DET_510;
    endproperty
    a_h511_state: assert property (p_h511_state) else $error("Retimed 511 not after state 510");

    property p_frame_fall;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        $fell(frame_ff) |-> $past(h511_ff) && !h511_ff;
    endproperty
    a_frame_fall: assert property (p_frame_fall) else $error("Frame fell off 511");

    property p_frame_rise;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(frame_ff) |-> $past(h256_ff) && !h256_ff;
    endproperty
    a_frame_rise: assert property (p_frame_rise) else $error("Frame rose off 256");

    property p_half_toggle;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        $changed(half_ff) |-> $past(h511_ff) && $past(fast_tick) && !h511_ff;
    endproperty
    a_half_toggle: assert property (p_half_toggle) else $error("Half-frame moved off 511");

    property p_xor_move;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        $changed(xor_ff) |-> $past(h256_ff) && $past(fast_tick);
    endproperty
    a_xor_move: assert property (p_xor_move) else $error("Frame xor moved off 256");

    property p_slow_on_half_fall;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        slow_tick |-> fast_tick && half_ff ##1 !half_ff;
    endproperty
    a_slow_on_half_fall: assert property (p_slow_on_half_fall) else $error("Slow tick not at half fall");

    property p_slow_period;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (slow_tick && chk_slow_seen_ff) |-> chk_fast_cnt_ff == 11'(SLOW_DIVIDE) + chk_slow_extra_ff;
    endproperty
    a_slow_period: assert property (p_slow_period) else $error("Slow period not 1022 fast ticks");

    property p_frame_period;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (fall_511 && chk_frame_seen_ff) |->
            chk_frame_cnt_ff == (chk_frame_slip_ff ? 10'(H_PERIOD + H_SLIP_BITS) : 10'(H_PERIOD));
    endproperty
    a_frame_period: assert property (p_frame_period) else $error("Frame period not 511");

    property p_fast_recur;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (fast_tick && !seq.h_zero8) |=> seq.h_state[0] == ($past(seq.h_state[8]) ^ $past(seq.h_state[3]));
    endproperty
    a_fast_recur: assert property (p_fast_recur) else $error("Fast recurrence broken");

endmodule

// File: tb/pnccg_far_model.sv
// =============================================================================
// Far side: reference source and phase slip controller
// =============================================================================
// Makes the double-rate reference and slips the fast code on request.
// Assumes it shares the system clock with the timing core.
module pnccg_far_model import pnccg_pkg::*;
(
    // Clock and reset
    input  wire logic                sys_clk_i,
    input  wire logic                sys_rst_i,
    // Bench request and view of the core
    input  wire logic                slip_req_i,
    input  wire logic                fast_code_clock_i,
    input  wire logic [H_STAGES-1:0] fast_stages_i,
    // Toward the core
    output logic                     double_rate_reference_o,
    output logic                     phase_slip_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] ref_cnt_ff;
    logic       after_510_ff;

    // Reference at an eighth of the system clock
    assign double_rate_reference_o = ref_cnt_ff[2];

    // Slip only over the one tick after state 510, else a repeated 511 slips twice
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            {ref_cnt_ff, after_510_ff, phase_slip_o} <= 5'h00;
        else
        begin
            ref_cnt_ff <= ref_cnt_ff + 3'h1;
            if (fast_code_clock_i)
                {after_510_ff, phase_slip_o} <= {fast_stages_i == 9'h100, 1'b0};
            else if (after_510_ff && slip_req_i)
                phase_slip_o <= 1'b1;
        end
    end
endmodule

// File: tb/tb_pnccg_top.sv
// =============================================================================
// Self-checking bench of the code clock generator
// =============================================================================
// A model tracks sequences and frame waves; outputs are checked before each tick.
// Assumes the far-side model supplies reference and slips.
module tb_pnccg_top import pnccg_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic                sys_clk_i, sys_rst_i, double_rate_reference_i, phase_slip_i, slip_req;
    logic                fast_code_clock_o, slow_code_clock_o, fast_clock_gate_o, slow_clock_gate_o;
    logic                fast_square_o, fast_seq_o, slow_seq_o, state_256_o, state_511_o;
    logic                frame_o, half_frame_o, frame_xor_o, m_511, m_256, m_frame, m_half;
    logic [H_STAGES-1:0] fast_stages_o, m_st;
    logic [L_STAGES-1:0] slow_stages_o, m_l;
    int                  m_k, m_gap, fails = 0, total_checks = 0;
    int                  row_n[3] = '{1100, 1030, 1100};
    logic                row_slip[3] = '{1'b0, 1'b1, 1'b0};

    pnccg_top DUT (.sys_clk_i, .sys_rst_i, .double_rate_reference_i, .phase_slip_i, .fast_code_clock_o,
        .slow_code_clock_o, .fast_clock_gate_o, .slow_clock_gate_o, .fast_square_o, .fast_stages_o,
        .slow_stages_o, .fast_seq_o, .slow_seq_o, .state_256_o, .state_511_o, .frame_o, .half_frame_o,
        .frame_xor_o);
    pnccg_far_model far (.sys_clk_i, .sys_rst_i, .slip_req_i(slip_req), .fast_code_clock_i(fast_code_clock_o),
        .fast_stages_i(fast_stages_o), .double_rate_reference_o(double_rate_reference_i),
        .phase_slip_o(phase_slip_i));

    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk9(input logic [8:0] got, input logic [8:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic run_ticks(input int n);
        int c = 0;
        while (c < n)
        begin
            @(negedge sys_clk_i);
            if (fast_code_clock_o === 1'b1)
                c++;
        end
        @(posedge sys_clk_i);
        #1;
    endtask

    task automatic finish_test;
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Model: compare the settled outputs, then step as the tick edge will
    always @(negedge sys_clk_i)
    begin
        // Thirteen cycles run from release to the first tick with this reference
        m_gap = sys_rst_i ? 3 : m_gap + 1;
        if (sys_rst_i)
        begin
            {m_st, m_l, m_k} = {9'h002, 7'h02, 32'd1};
            {m_511, m_256, m_frame, m_half} = 4'h0;
        end
        else if (fast_code_clock_o)
        begin
            chk9(fast_stages_o, m_st);
            chk1(fast_seq_o, m_st[8]);
            chk9({2'b00, slow_stages_o}, {2'b00, m_l});
            chk1(state_511_o, m_511);
            chk1(state_256_o, m_256);
            chk1(frame_o, m_frame);
            chk1(half_frame_o, m_half);
            chk1(frame_xor_o, m_frame ^ m_half);
            chk1(slow_code_clock_o, m_511 & m_half);
            chk1(slow_clock_gate_o, m_511 & m_half);
            chk1(fast_clock_gate_o & ~fast_square_o, 1'b1);
            chk9(9'(m_gap), 9'h010);
            chk1(slow_seq_o, m_l[6]);
            m_gap = 0;
            if (m_511 & m_half)
                m_l = {m_l[5:0], m_l[6] ^ m_l[5]};
            if (m_511)
                {m_frame, m_half} = {1'b0, ~m_half};
            if (m_256)
                m_frame = 1'b1;
            {m_511, m_256} = {m_k == 510, m_k == 255};
            m_st = {m_st[7:0], (m_st[8] ^ m_st[3]) | (m_st[7:0] == 8'h00)};
            if (phase_slip_i)
                m_st[1] = 1'b0;
            m_k = phase_slip_i ? 0 : (m_k == 0 ? 511 : m_k % 511 + 1);
        end
    end

    // Clock
    initial
    begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // Watchdog
    initial
    begin
        #800_000;
        fails++;
        finish_test();
    end

    // Rows of tick counts with slip requests, then a mid-run reset
    initial
    begin
        {sys_rst_i, slip_req} = 2'b10;
        repeat (2) @(posedge sys_clk_i);
        #1 sys_rst_i = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            slip_req = row_slip[i];
            run_ticks(row_n[i]);
            $display("row %0d done", i);
        end
        {sys_rst_i, slip_req} = 2'b10;
        #2;
        chk9(fast_stages_o, 9'h002);
        chk9({2'b00, slow_stages_o}, 9'h002);
        chk1(fast_code_clock_o | slow_code_clock_o | frame_o, 1'b0);
        @(posedge sys_clk_i);
        #1 sys_rst_i = 1'b0;
        run_ticks(300);
        $display("reset test done");
        finish_test();
    end
endmodule
